/* File: hw/aeil_pkg.sv */
// Constants, register map and bus carriers of the interrupt line logic.
// Assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
package aeil_pkg;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_ARM = 8'h00; // Arm bits, rw
	localparam logic [7:0] OFS_ENABLE = 8'h04; // Enable bits, rw
	localparam logic [7:0] OFS_REQUEST = 8'h08; // Request bits ro, write 1 asks
	localparam logic [7:0] OFS_PENDING = 8'h0c; // Pending bits, write 1 clears
	localparam logic [7:0] OFS_LEVEL = 8'h10; // 1 = level mode, 0 = edge
	localparam logic [7:0] OFS_INVERT = 8'h14; // 1 = falling/low active
	localparam logic [7:0] OFS_MAP_EN = 8'h18; // Input to chain line map enable
	localparam logic [7:0] OFS_MAP_SEL0 = 8'h1c; // Chain index, inputs 0..7
	localparam logic [7:0] OFS_MAP_SEL1 = 8'h20; // Chain index, inputs 8..15
	localparam logic [7:0] OFS_STATE = 8'h24; // Filtered input levels, ro
	localparam logic [7:0] OFS_VECTOR = 8'h28; // Last delivered vector, ro
	// ****************************************
	// Reset values and field layout
	// ****************************************
	localparam logic [31:0] RST_ZERO = 32'h0; // Arm, enable and config reset
	localparam int MAP_FIELD_W = 4; // Bits per map index field
	localparam int MAP_PER_REG = 8; // Map fields per word
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// Source timing
	// ****************************************
	localparam int HOLD_NS = 1500; // Least source hold time, ns
	localparam int CLK_NS = 50; // System clock period, ns
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS; // Rounded up
	// ****************************************
	// Bus carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} aeil_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} aeil_axi_rsp_t;
endpackage

/* File: hw/aeil_core.sv */
// Arm/enable interrupt lines for external inputs and chain lines.
// Assumes AXI4-Lite software access and asynchronous pin inputs.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
module aeil_core import aeil_pkg::*; #(
	parameter int N_EXT = 12,
	parameter int N_DIST = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire aeil_axi_req_t i_axi,
	output aeil_axi_rsp_t o_axi,
	input wire logic [N_EXT-1:0] i_ext,
	input wire logic [N_DIST-1:0] i_chain_in,
	output logic [N_DIST-1:0] o_chain_out,
	output logic o_host_irq,
	output logic o_irq_pulse,
	output logic [$clog2(N_EXT+N_DIST)-1:0] o_irq_vector
);
	localparam int L = N_EXT + N_DIST; // External lines first, chain lines above
	localparam int VW = $clog2(L);

	// ****************************************
	// Helpers
	// ****************************************
	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Lowest set bit as a one-hot word
	function automatic logic [L-1:0] lowest(input logic [L-1:0] v);
		logic [L-1:0] r;
		r = '0;
		for (int i = L - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = '0;
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction

	// Index of a one-hot word
	function automatic logic [VW-1:0] index_of(input logic [L-1:0] v);
		logic [VW-1:0] r;
		r = '0;
		for (int i = 0; i < L; i++) begin
			if (v[i]) begin
				r = VW'(i);
			end
		end
		return r;
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic [L-1:0] sync1_reg, sync2_reg, sync3_reg; // Pin synchroniser stages
	logic [L-1:0] filt_reg, filt_next; // Agreed input level
	logic [L-1:0] asrt_reg, asrt_next; // Active level seen last cycle
	logic [L-1:0] arm_reg, arm_next; // Arm bit per line
	logic [L-1:0] en_reg, en_next; // Enable bit per line
	logic [L-1:0] req_reg, req_next; // Latched requests
	logic [L-1:0] pend_reg, pend_next; // Delivered, awaiting host clear
	logic [L-1:0] lvl_reg, lvl_next; // Level mode select
	logic [L-1:0] inv_reg, inv_next; // Falling/low active select
	logic [N_EXT-1:0] mapen_reg, mapen_next; // Input mapped to chain line
	logic [63:0] mapsel_reg, mapsel_next; // Chain index fields
	logic [N_DIST-1:0] chain_reg, chain_next; // Chain outputs
	logic irq_reg, irq_next; // One-cycle delivery strobe
	logic [VW-1:0] vec_reg, vec_next; // Vector of last delivery
	logic aw_hold_reg, aw_hold_next; // Write address taken
	logic [7:0] awaddr_reg, awaddr_next;
	logic w_hold_reg, w_hold_next; // Write data taken
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	// ****************************************
	// Synchroniser, runs on every pin
	// ****************************************
	// Three stages; a source holding each level for its least time passes
	// through the agreement filter well inside one hold
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= {i_chain_in, i_ext};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// ****************************************
	// Recognition, requests and delivery
	// ****************************************
	logic [L-1:0] act, evt, swreq, hit, cand, dlv, clr;
	logic wr_go;

	// Next values of line state
	always_comb begin
		wr_go = aw_hold_reg & w_hold_reg & ~bvalid_reg;
		// Level counts once stages two and three agree
		for (int i = 0; i < L; i++) begin
			filt_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : filt_reg[i];
		end
		act = filt_reg ^ inv_reg; // Active high unless inverted
		asrt_next = act;
		// Edge mode fires once per new assertion
		// Level mode fires while active
		evt = (lvl_reg & act) | (~lvl_reg & act & ~asrt_reg);
		// Software asks set only the local request bit
		swreq = (wr_go && awaddr_reg == OFS_REQUEST) ? wdata_reg[L-1:0] : '0;
		clr = (wr_go && awaddr_reg == OFS_PENDING) ? wdata_reg[L-1:0] : '0;
		arm_next = arm_reg;
		en_next = en_reg;
		lvl_next = lvl_reg;
		inv_next = inv_reg;
		mapen_next = mapen_reg;
		mapsel_next = mapsel_reg;
		if (wr_go) begin
			case (awaddr_reg)
				// Independent bit per line; map select words hold 4-bit chain index fields
				OFS_ARM: arm_next = L'(wmerge(32'(arm_reg), wdata_reg, wstrb_reg));
				OFS_ENABLE: en_next = L'(wmerge(32'(en_reg), wdata_reg, wstrb_reg));
				OFS_LEVEL: lvl_next = L'(wmerge(32'(lvl_reg), wdata_reg, wstrb_reg));
				OFS_INVERT: inv_next = L'(wmerge(32'(inv_reg), wdata_reg, wstrb_reg));
				OFS_MAP_EN: mapen_next = N_EXT'(wmerge(32'(mapen_reg), wdata_reg, wstrb_reg));
				OFS_MAP_SEL0: mapsel_next[31:0] = wmerge(mapsel_reg[31:0], wdata_reg, wstrb_reg);
				OFS_MAP_SEL1: mapsel_next[63:32] = wmerge(mapsel_reg[63:32], wdata_reg, wstrb_reg);
				default: ;
			endcase
		end
		// Only armed lines latch; disabled ones still do
		hit = (evt | swreq) & arm_reg;
		// Enabled, not pending requests compete
		cand = req_reg & en_reg & arm_reg & ~pend_reg;
		dlv = lowest(cand); // Fixed order, lowest first
		// New hit wins over the clear by delivery; disarm wipes
		req_next = ((req_reg & ~dlv) | hit) & arm_next;
		// Pending held until host write-1 clear
		pend_next = (pend_reg & ~clr) | dlv;
		irq_next = |dlv;
		// Vector is the line index, chain lines above inputs
		vec_next = (|dlv) ? index_of(dlv) : vec_reg;
		// Mapped filtered active levels drive chain lines, local logic bypassed
		chain_next = '0;
		for (int e = 0; e < N_EXT; e++) begin
			for (int d = 0; d < N_DIST; d++) begin
				if (mapen_reg[e] && 32'(mapsel_reg[MAP_FIELD_W*e +: MAP_FIELD_W]) == d) begin
					chain_next[d] = chain_next[d] | act[e];
				end
			end
		end
	end

	// Line state registers; reset leaves all lines disarmed, disabled
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			filt_reg <= '0;
			asrt_reg <= '0;
			arm_reg <= L'(RST_ZERO);
			en_reg <= L'(RST_ZERO);
			req_reg <= '0;
			pend_reg <= '0;
			lvl_reg <= L'(RST_ZERO);
			inv_reg <= L'(RST_ZERO);
			mapen_reg <= N_EXT'(RST_ZERO);
			mapsel_reg <= {RST_ZERO, RST_ZERO};
			chain_reg <= '0;
			irq_reg <= 1'b0;
			vec_reg <= '0;
		end else begin
			filt_reg <= filt_next;
			asrt_reg <= asrt_next;
			arm_reg <= arm_next;
			en_reg <= en_next;
			req_reg <= req_next;
			pend_reg <= pend_next;
			lvl_reg <= lvl_next;
			inv_reg <= inv_next;
			mapen_reg <= mapen_next;
			mapsel_reg <= mapsel_next;
			chain_reg <= chain_next;
			irq_reg <= irq_next;
			vec_reg <= vec_next;
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic aw_take, w_take, ar_take, wr_ok;

	// Next values of bus state
	always_comb begin
		aw_take = i_axi.awvalid & ~aw_hold_reg & ~bvalid_reg;
		w_take = i_axi.wvalid & ~w_hold_reg & ~bvalid_reg;
		ar_take = i_axi.arvalid & ~rvalid_reg;
		aw_hold_next = aw_hold_reg;
		awaddr_next = awaddr_reg;
		w_hold_next = w_hold_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		// Address and data taken in either order
		if (aw_take) begin
			aw_hold_next = 1'b1;
			awaddr_next = i_axi.awaddr;
		end
		if (w_take) begin
			w_hold_next = 1'b1;
			wdata_next = i_axi.wdata;
			wstrb_next = i_axi.wstrb;
		end
		// Both held: register update and response
		wr_ok = awaddr_reg[1:0] == 2'h0 && awaddr_reg <= OFS_MAP_SEL1;
		if (wr_go) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && i_axi.bready) begin
			bvalid_next = 1'b0;
		end
		// Read answer one cycle after the address
		if (ar_take) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			case (i_axi.araddr)
				OFS_ARM: rdata_next = 32'(arm_reg);
				OFS_ENABLE: rdata_next = 32'(en_reg);
				OFS_REQUEST: rdata_next = 32'(req_reg);
				OFS_PENDING: rdata_next = 32'(pend_reg);
				OFS_LEVEL: rdata_next = 32'(lvl_reg);
				OFS_INVERT: rdata_next = 32'(inv_reg);
				OFS_MAP_EN: rdata_next = 32'(mapen_reg);
				OFS_MAP_SEL0: rdata_next = mapsel_reg[31:0];
				OFS_MAP_SEL1: rdata_next = mapsel_reg[63:32];
				OFS_STATE: rdata_next = 32'(filt_reg);
				OFS_VECTOR: rdata_next = 32'(vec_reg);
				default: begin
					rdata_next = 32'h0;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && i_axi.rready) begin
			rvalid_next = 1'b0;
		end
	end

	// Bus registers
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg <= 8'h0;
			w_hold_reg <= 1'b0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= 2'h0;
		end else begin
			aw_hold_reg <= aw_hold_next;
			awaddr_reg <= awaddr_next;
			w_hold_reg <= w_hold_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		o_axi.awready = ~aw_hold_reg & ~bvalid_reg;
		o_axi.wready = ~w_hold_reg & ~bvalid_reg;
		o_axi.bvalid = bvalid_reg;
		o_axi.bresp = bresp_reg;
		o_axi.arready = ~rvalid_reg;
		o_axi.rvalid = rvalid_reg;
		o_axi.rdata = rdata_reg;
		o_axi.rresp = rresp_reg;
	end
	assign o_chain_out = chain_reg;
	assign o_host_irq = |pend_reg; // Host line while any delivery awaits service
	assign o_irq_pulse = irq_reg;
	assign o_irq_vector = vec_reg;
endmodule // aeil_core

/* File: tb/aeil_src.sv */
// Pin source model driving the core's external inputs.
// Assumes the bench asks for levels; pins follow after the hold time.
`timescale 1ns/10ps
module aeil_src import aeil_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [11:0] i_want,
	output logic [11:0] o_ext
);
	int hold_reg; // Cycles since the last change
	// ****************************************
	// Pins move only once each level has stood long enough
	// ****************************************
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ext <= '0;
			hold_reg <= 0;
		end else if (hold_reg >= HOLD_CYC && o_ext != i_want) begin
			o_ext <= i_want;
			hold_reg <= 0;
		end else begin
			hold_reg <= hold_reg + 1;
		end
	end
endmodule // aeil_src

/* File: tb/aeil_core_sva.sv */
// Checker of bus answers and delivery at the core's ports.
// Assumes one clock and an active low async reset.
`timescale 1ns/10ps
module aeil_core_chk import aeil_pkg::*; #(
	parameter int N_EXT = 12,
	parameter int N_DIST = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire aeil_axi_req_t i_axi,
	input wire aeil_axi_rsp_t o_axi,
	input wire logic [N_EXT-1:0] i_ext,
	input wire logic [N_DIST-1:0] i_chain_in,
	input wire logic [N_DIST-1:0] o_chain_out,
	input wire logic o_host_irq,
	input wire logic o_irq_pulse,
	input wire logic [$clog2(N_EXT+N_DIST)-1:0] o_irq_vector
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// Both write channels taken at one edge
	sequence s_wr_taken;
		i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
	endsequence
	// No delivery and no chain drive
	sequence s_quiet;
		!o_irq_pulse && !o_host_irq && o_chain_out == '0;
	endsequence
	property p_rst_quiet;
		$rose(i_reset_n) |-> s_quiet [*8];
	endproperty
	property p_pulse_host;
		o_irq_pulse |-> o_host_irq;
	endproperty
	property p_vec;
		o_irq_pulse |-> o_irq_vector < N_EXT + N_DIST;
	endproperty
	property p_clear;
		$fell(o_host_irq) |-> $rose(o_axi.bvalid);
	endproperty
	// Both channels held for one cycle, then the answer rises
	property p_b_after;
		s_wr_taken |-> ##2 o_axi.bvalid;
	endproperty
	property p_aw_low;
		o_axi.bvalid |-> !o_axi.awready && !o_axi.wready;
	endproperty
	property p_r_after;
		i_axi.arvalid && o_axi.arready |=> o_axi.rvalid;
	endproperty
	property p_r_low;
		o_axi.rvalid |-> !o_axi.arready;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("Activity after reset");
	a_pulse_host: assert property (p_pulse_host) else $error("Pulse without host irq");
	a_vec: assert property (p_vec) else $error("Vector out of range");
	a_clear: assert property (p_clear) else $error("Pending dropped alone");
	a_b_after: assert property (p_b_after) else $error("No write answer");
	a_aw_low: assert property (p_aw_low) else $error("Write ready early");
	a_r_after: assert property (p_r_after) else $error("No read answer");
	a_r_low: assert property (p_r_low) else $error("Read ready early");
endmodule // aeil_core_chk
bind aeil_core aeil_core_chk #(.N_EXT(N_EXT), .N_DIST(N_DIST)) aeil_core_chk_i (
	.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_axi(i_axi), .o_axi(o_axi),
	.i_ext(i_ext), .i_chain_in(i_chain_in), .o_chain_out(o_chain_out),
	.o_host_irq(o_host_irq), .o_irq_pulse(o_irq_pulse), .o_irq_vector(o_irq_vector));

/* File: tb/armed_enabled_interrupt_logic_tb_top.sv */
// Bench: AXI4-Lite host tasks, pin source, self checks.
// Assumes the core's default line counts.
`timescale 1ns/10ps
module armed_enabled_interrupt_logic_tb_top import aeil_pkg::*;;
	logic clk = 1'b0; // 20 MHz clock
	logic reset_n = 1'b0; // Active low reset
	aeil_axi_req_t req = '0; // Host requests
	aeil_axi_rsp_t rsp; // Device answers
	logic [11:0] want = '0; // Levels asked of the source
	logic [11:0] ext; // Pins
	logic [7:0] chain_in = '0; // Chain lines in
	logic [7:0] chain_out;
	logic host_irq;
	logic pulse;
	logic [4:0] vec;
	logic [31:0] seed = 32'hde8e; // Random state
	logic [31:0] rdat; // Last read data
	logic [1:0] rrsp; // Last read response
	logic [1:0] brsp; // Last write response
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	always #25 clk = ~clk;
	aeil_src aeil_src_i (.i_sys_clk(clk), .i_reset_n(reset_n), .i_want(want), .o_ext(ext));
	aeil_core aeil_core_i (.i_sys_clk(clk), .i_reset_n(reset_n), .i_axi(req), .o_axi(rsp),
		.i_ext(ext), .i_chain_in(chain_in), .o_chain_out(chain_out),
		.o_host_irq(host_irq), .o_irq_pulse(pulse), .o_irq_vector(vec));
	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Arm bits kept: one per line
	function automatic logic [31:0] arm_exp(input logic [31:0] d);
		return d & 32'hfffff;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Write: both channels offered, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req.awaddr <= a;
		req.wdata <= d;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		brsp = rsp.bresp;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		rdat = rsp.rdata;
		rrsp = rsp.rresp;
		chk(rdat, e);
	endtask
	task automatic wait_pulse(input logic [4:0] v);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pulse !== 1'b1 && n < 100);
		chk(pulse, 1'b1);
		chk(vec, v);
		chk(host_irq, 1'b1);
	endtask
	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge clk);
			if (pulse !== 1'b0) seen = 1'b1;
		end
		chk(seen, 1'b0);
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		req.rready <= 1'b1;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rc(OFS_ARM, 32'h0);
		rc(OFS_ENABLE, 32'h0);
		rc(OFS_MAP_EN, 32'h0);
		rc(8'h2c, 32'h0);
		chk(rrsp, RESP_SLVERR);
		// Read-only word refuses a write and keeps its value
		wr(OFS_VECTOR, 32'h1f);
		chk(brsp, RESP_SLVERR);
		rc(OFS_VECTOR, 32'h0);
		for (int i = 0; i < 8; i++) begin
			rdat = xs();
			wr(OFS_ARM, rdat);
			chk(brsp, RESP_OKAY);
			rc(OFS_ARM, arm_exp(rdat));
		end
		wr(OFS_ARM, 32'h0);
		$display("test registers done");
		want <= 12'h008;
		quiet(60);
		rc(OFS_REQUEST, 32'h0);
		wr(OFS_ARM, 32'h1);
		wr(OFS_ENABLE, 32'h1);
		want <= 12'h009;
		wait_pulse(5'h0);
		rc(OFS_PENDING, 32'h1);
		quiet(60);
		wr(OFS_PENDING, 32'h1);
		quiet(60);
		want <= 12'h008;
		quiet(40);
		want <= 12'h009;
		wait_pulse(5'h0);
		wr(OFS_PENDING, 32'h1);
		$display("test edge done");
		wr(OFS_ARM, 32'h7);
		want <= 12'h00f;
		quiet(60);
		rc(OFS_REQUEST, 32'h6);
		wr(OFS_ARM, 32'h3);
		rc(OFS_REQUEST, 32'h2);
		wr(OFS_ENABLE, 32'h3);
		wait_pulse(5'h1);
		wr(OFS_PENDING, 32'h2);
		wr(OFS_ARM, 32'h30);
		wr(OFS_REQUEST, 32'h30);
		wr(OFS_ENABLE, 32'h30);
		wait_pulse(5'h4);
		wait_pulse(5'h5);
		chk(chain_out, 8'h0);
		wr(OFS_PENDING, 32'h30);
		$display("test enable done");
		wr(OFS_ARM, 32'h0);
		wr(OFS_MAP_SEL0, 32'h30000);
		wr(OFS_MAP_EN, 32'h10);
		want <= 12'h01f;
		quiet(60);
		chk(chain_out, 8'h08);
		want <= 12'h00f;
		quiet(60);
		chk(chain_out, 8'h0);
		// Software ask on a mapped input stays off the chain
		wr(OFS_ARM, 32'h10);
		wr(OFS_REQUEST, 32'h10);
		chk(chain_out, 8'h0);
		wait_pulse(5'h4);
		wr(OFS_PENDING, 32'h10);
		wr(OFS_LEVEL, 32'h40);
		wr(OFS_ARM, 32'h40);
		wr(OFS_ENABLE, 32'h40);
		want <= 12'h04f;
		wait_pulse(5'h6);
		wr(OFS_PENDING, 32'h40);
		wait_pulse(5'h6);
		wr(OFS_ARM, 32'h1000);
		wr(OFS_ENABLE, 32'h1000);
		chain_in <= 8'h01;
		wr(OFS_PENDING, 32'h40);
		wait_pulse(5'hc);
		wr(OFS_PENDING, 32'hfffff);
		$display("test map and level done");
		// Falling edge on an inverted line; the rise stays silent
		wr(OFS_INVERT, 32'h80);
		wr(OFS_ARM, 32'h80);
		wr(OFS_ENABLE, 32'h80);
		want <= 12'h0cf;
		quiet(60);
		want <= 12'h04f;
		wait_pulse(5'h7);
		rc(OFS_VECTOR, 32'h7);
		rc(OFS_STATE, 32'h104f);
		// Reset in mid-run drops every setting and pending bit
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rc(OFS_ARM, 32'h0);
		rc(OFS_ENABLE, 32'h0);
		chk(host_irq, 1'b0);
		$display("test invert and reset done");
		tally_and_finish();
	end
endmodule // armed_enabled_interrupt_logic_tb_top
